// >>> rtl/upstream_window_base_regs.sv
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
// Summary of operation
// - Bits 2:1 read-only width code: 00 32-bit, 01 64-bit, reset 00.
// - Bit 3 read-only prefetchable flag, reset zero.
// - Base bits 31:6 writable only where the setup register bit is one, except bits 31:8 in IO space, which are always writable.
// - Setup bit 31 at zero disables the window.
// - Window size 4KB to 2GB for memory, 64B to 256B for IO.
// - Hits are forwarded with address translated by the translated base register.
// - Base resets to zero; a zero base claims no transactions.
// - Setup register loadable by EEPROM, SMBus or local processor before enumeration.
module upstream_window_base_regs
	import bridge_win_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              reset,
	input  wire logic              ce,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              setup_load,
	input  wire logic [31:0]       setup_load_data,
	input  wire logic              txn_valid,
	input  wire logic [31:0]       txn_addr,
	input  wire logic              txn_is_io,
	output logic                   fwd_hit,
	output logic [31:0]            fwd_addr
);

	////////////////////////////////////////////////////////////////////////////
	// State

	logic [31:0]       setup_q;
	logic [31:0]       setup_d;
	logic [BASE_W-1:0] base_q;
	logic [BASE_W-1:0] base_d;
	logic [BASE_W-1:0] xlat_q;
	logic [BASE_W-1:0] xlat_d;
	logic [31:0]       rdata_q;
	logic [31:0]       rdata_d;
	logic              hit_q;
	logic              hit_d;
	logic [31:0]       fwd_q;
	logic [31:0]       fwd_d;

	logic              setup_phase;
	logic              access;
	logic              wr_fire;
	logic              mapped;
	logic [BASE_W-1:0] wmask;
	logic [1:0]        width_code;
	logic [31:0]       win1_read;
	logic [31:0]       read_mux;
	logic              dec_hit;
	logic [31:0]       dec_addr;

	window_cfg_if cfg_bus ();

	////////////////////////////////////////////////////////////////////////////
	// Attribute fields and writable mask

	// Size limits clip the setup bits so no bad window can be built
	always_comb begin
		if (setup_q[SPACE_BIT]) begin
			wmask = setup_q[31:BASE_LO] | ~IO_SIZE_MASK;
			wmask = wmask & IO_SIZE_MASK | (setup_q[31:BASE_LO] & ~IO_SIZE_MASK);
			wmask[BASE_W-1:IO_MAX_LO-BASE_LO] = '1;
		end else begin
			wmask = setup_q[31:BASE_LO] & MEM_SIZE_MASK;
		end
		// Reserved codes are not passed on; only 32 or 64 bit is reported
		width_code = (setup_q[TYPE_HI:TYPE_LO] == TYPE_64) ? TYPE_64 : TYPE_32;
	end

	// Read view of window 1: unwritable base bits and bits 5:4 read zero
	always_comb begin
		win1_read                      = '0;
		win1_read[SPACE_BIT]           = setup_q[SPACE_BIT];
		win1_read[TYPE_HI:TYPE_LO]     = width_code;
		win1_read[PREF_BIT]            = setup_q[PREF_BIT];
		win1_read[31:BASE_LO]          = base_q & wmask;
	end

	////////////////////////////////////////////////////////////////////////////
	// APB decode

	// One wait-free access phase; read data is captured in the setup cycle
	always_comb begin
		setup_phase = psel && !penable && ce;
		access      = psel && penable && ce;
		mapped      = (paddr == OFF_WIN1_BASE) || (paddr == OFF_WIN2_BASE)
			|| (paddr == OFF_WIN1_XLAT) || (paddr == OFF_WIN1_SETUP);
		wr_fire     = access && pwrite && mapped;
		pready      = access;
		pslverr     = access && !mapped;
		prdata      = rdata_q;
	end

	// Read multiplexer
	always_comb begin
		unique case (paddr)
			OFF_WIN1_BASE:  read_mux = win1_read;
			OFF_WIN2_BASE:  read_mux = WIN2_READ_VALUE;
			OFF_WIN1_XLAT:  read_mux = {xlat_q, 6'h00};
			OFF_WIN1_SETUP: read_mux = setup_q;
			default:        read_mux = '0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Register next state

	always_comb begin
		setup_d = setup_q;
		base_d  = base_q;
		xlat_d  = xlat_q;
		rdata_d = rdata_q;
		if (wr_fire) begin
			unique case (paddr)
				OFF_WIN1_BASE:  base_d  = (pwdata[31:BASE_LO] & wmask) | (base_q & ~wmask);
				OFF_WIN1_XLAT:  xlat_d  = pwdata[31:BASE_LO];
				OFF_WIN1_SETUP: setup_d = pwdata;
				default:        ;
			endcase
		end
		// Boot loader wins over software; it runs before enumeration anyway
		if (setup_load) begin
			setup_d = setup_load_data;
		end
		if (setup_phase && !pwrite) begin
			rdata_d = read_mux;
		end
	end

	// Registers, frozen while ce is low
	always_ff @(posedge clk) begin
		if (reset) begin
			setup_q <= SETUP_RESET;
			base_q  <= BASE_RESET;
			xlat_q  <= XLAT_RESET;
			rdata_q <= '0;
		end else if (ce) begin
			setup_q <= setup_d;
			base_q  <= base_d;
			xlat_q  <= xlat_d;
			rdata_q <= rdata_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Window decode and forwarding

	// Zero base or cleared enable bit leaves the window dead
	assign cfg_bus.base    = base_q & wmask;
	assign cfg_bus.mask    = wmask;
	assign cfg_bus.xlat    = xlat_q;
	assign cfg_bus.is_io   = setup_q[SPACE_BIT];
	assign cfg_bus.enabled = setup_q[ENABLE_BIT] && ((base_q & wmask) != '0);

	window1_decoder u_decoder (
		.cfg       (cfg_bus),
		.addr      (txn_addr),
		.addr_is_io(txn_is_io),
		.hit       (dec_hit),
		.xlat_addr (dec_addr)
	);

	// Forwarded address holds until the next hit
	always_comb begin
		hit_d = txn_valid && dec_hit;
		fwd_d = fwd_q;
		if (txn_valid && dec_hit) begin
			fwd_d = dec_addr;
		end
		fwd_hit  = hit_q;
		fwd_addr = fwd_q;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			hit_q <= 1'b0;
			fwd_q <= '0;
		end else if (ce) begin
			hit_q <= hit_d;
			fwd_q <= fwd_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks

	sequence s_base_read;
		setup_phase && !pwrite && paddr == OFF_WIN1_BASE ##1 access;
	endsequence

	sequence s_txn_hit;
		txn_valid && ce && dec_hit;
	endsequence

	chk_width_code: assert property (@(posedge clk) disable iff (reset)
		s_base_read |-> prdata[TYPE_HI] == 1'b0
			&& prdata[TYPE_LO] == ($past(setup_q[TYPE_HI:TYPE_LO]) == TYPE_64))
		else $error("width code reads wrong");

	chk_prefetch_flag: assert property (@(posedge clk) disable iff (reset)
		s_base_read |-> prdata[PREF_BIT] == $past(setup_q[PREF_BIT]))
		else $error("prefetch flag reads wrong");

	chk_base_write_mask: assert property (@(posedge clk) disable iff (reset)
		wr_fire && paddr == OFF_WIN1_BASE |=> base_q ==
			(($past(pwdata[31:BASE_LO]) & $past(wmask)) | ($past(base_q) & ~$past(wmask))))
		else $error("base write ignored the setup mask");

	chk_disable_bit: assert property (@(posedge clk) disable iff (reset)
		txn_valid && ce && !setup_q[ENABLE_BIT] |=> !fwd_hit)
		else $error("disabled window claimed a transaction");

	chk_size_limits: assert property (@(posedge clk) disable iff (reset)
		setup_q[SPACE_BIT] ? (&wmask[BASE_W-1:IO_MAX_LO-BASE_LO])
			: (wmask[MEM_MIN_LO-BASE_LO-1:0] == '0))
		else $error("window size out of range");

	chk_xlat_addr: assert property (@(posedge clk) disable iff (reset)
		s_txn_hit |=> fwd_hit && fwd_addr[31:BASE_LO] ==
			(($past(xlat_q) & $past(wmask)) | ($past(txn_addr[31:BASE_LO]) & ~$past(wmask)))
			&& fwd_addr[BASE_LO-1:0] == $past(txn_addr[BASE_LO-1:0]))
		else $error("forwarded address not translated");

	chk_zero_base: assert property (@(posedge clk) disable iff (reset)
		txn_valid && ce && (base_q & wmask) == '0 |=> !fwd_hit)
		else $error("zero base claimed a transaction");

	chk_setup_load: assert property (@(posedge clk) disable iff (reset)
		setup_load && ce |=> setup_q == $past(setup_load_data))
		else $error("setup load not taken");

	chk_reserved_zero: assert property (@(posedge clk) disable iff (reset)
		s_base_read |-> prdata[5:4] == 2'h0
			&& (prdata[31:BASE_LO] & ~$past(wmask)) == '0)
		else $error("reserved or unwritable bits read nonzero");

endmodule : upstream_window_base_regs

// >>> common/bridge_win_pkg.sv
package bridge_win_pkg;

	// Register byte offsets on the APB
	localparam int unsigned   ADDR_W          = 12;
	localparam logic [11:0]   OFF_WIN1_BASE   = 12'h058;
	localparam logic [11:0]   OFF_WIN2_BASE   = 12'h05c;
	localparam logic [11:0]   OFF_WIN1_XLAT   = 12'h0e8;
	localparam logic [11:0]   OFF_WIN1_SETUP  = 12'h0ec;

	// Field positions in the window 1 base register and its setup register
	localparam int unsigned   SPACE_BIT       = 0;
	localparam int unsigned   TYPE_LO         = 1;
	localparam int unsigned   TYPE_HI         = 2;
	localparam int unsigned   PREF_BIT        = 3;
	localparam int unsigned   BASE_LO         = 6;
	localparam int unsigned   BASE_W          = 26;
	localparam int unsigned   ENABLE_BIT      = 31;

	// Window size limits: memory 4KB..2GB, IO 64B..256B
	localparam int unsigned   MEM_MIN_LO      = 12;
	localparam int unsigned   IO_MAX_LO       = 8;
	localparam logic [25:0]   MEM_SIZE_MASK   = 26'h3ffffc0;
	localparam logic [25:0]   IO_SIZE_MASK    = 26'h3fffffc;

	// Address width codes
	localparam logic [1:0]    TYPE_32         = 2'h0;
	localparam logic [1:0]    TYPE_64         = 2'h1;

	// Reset values
	localparam logic [31:0]   SETUP_RESET     = 32'h00000000;
	localparam logic [25:0]   BASE_RESET      = 26'h0000000;
	localparam logic [25:0]   XLAT_RESET      = 26'h0000000;
	localparam logic [31:0]   WIN2_READ_VALUE = 32'h00000000;

endpackage : bridge_win_pkg

// >>> common/window_cfg_if.sv
`timescale 1ns/1ps
// Window 1 configuration handed from the register bank to the decoder
interface window_cfg_if;
	logic [25:0] base;
	logic [25:0] mask;
	logic [25:0] xlat;
	logic        is_io;
	logic        enabled;

	modport cfg (
		output base,
		output mask,
		output xlat,
		output is_io,
		output enabled
	);
	modport dec (
		input  base,
		input  mask,
		input  xlat,
		input  is_io,
		input  enabled
	);
endinterface : window_cfg_if

// >>> rtl/window1_decoder.sv
`timescale 1ns/1ps
module window1_decoder
	import bridge_win_pkg::*;
(
	window_cfg_if.dec        cfg,
	input  wire logic [31:0] addr,
	input  wire logic        addr_is_io,
	output logic             hit,
	output logic [31:0]      xlat_addr
);

	// Claim only when enabled, same space and masked base bits match
	always_comb begin
		hit = cfg.enabled && (addr_is_io == cfg.is_io)
			&& (((addr[31:BASE_LO] ^ cfg.base) & cfg.mask) == '0);
		// Window bits replaced by the translated base, offset kept
		xlat_addr = {(cfg.xlat & cfg.mask) | (addr[31:BASE_LO] & ~cfg.mask),
			addr[BASE_LO-1:0]};
	end

endmodule : window1_decoder

// >>> verification/far_side_model.sv
`timescale 1ns/1ps
// Far side: upstream bus master and setup loader
module far_side_model (
	input  wire logic   clk,
	output logic        txn_valid,
	output logic [31:0] txn_addr,
	output logic        txn_is_io,
	output logic        setup_load,
	output logic [31:0] setup_load_data
);
	initial begin
		txn_valid = 1'b0;
		txn_addr = 32'h0;
		txn_is_io = 1'b0;
		setup_load = 1'b0;
		setup_load_data = 32'h0;
	end
	// One address per call; lines scrambled once released so stale values never match
	task automatic send(input logic [31:0] a, input logic io);
		@(posedge clk);
		txn_valid <= 1'b1;
		txn_addr <= a;
		txn_is_io <= io;
		@(posedge clk);
		txn_valid <= 1'b0;
		txn_addr <= ~a;
		txn_is_io <= ~io;
	endtask : send
	// Loader strobe, same path for EEPROM, SMBus or local CPU
	task automatic load(input logic [31:0] v);
		@(posedge clk);
		setup_load <= 1'b1;
		setup_load_data <= v;
		@(posedge clk);
		setup_load <= 1'b0;
		setup_load_data <= ~v;
	endtask : load
endmodule : far_side_model

// >>> verification/upstream_window_base_regs_tb.sv
`timescale 1ns/1ps
module upstream_window_base_regs_tb;
	import bridge_win_pkg::*;
	logic        clk = 1'b0;
	logic        reset = 1'b1;
	logic        ce = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready, pslverr, tv, tio, sl, hit;
	logic [31:0] ta, sld, fwd;
	int          n_mismatch = 0;
	int          num_checks = 0;
	////////////////////////////////////////////////////////////////////////
	initial begin
		forever #5 clk = ~clk;
	end
	upstream_window_base_regs i_dut (.clk(clk), .reset(reset), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .setup_load(sl),
		.setup_load_data(sld), .txn_valid(tv), .txn_addr(ta), .txn_is_io(tio),
		.fwd_hit(hit), .fwd_addr(fwd));
	far_side_model m (.clk(clk), .txn_valid(tv), .txn_addr(ta), .txn_is_io(tio),
		.setup_load(sl), .setup_load_data(sld));
	////////////////////////////////////////////////////////////////////////
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// APB transfer; waits for pready under a bound
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		int i;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		if (i == 16) begin
			n_mismatch++;
			tally_and_finish();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask : wr
	task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] x);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		chk(nm, x, r);
	endtask : rdchk
	// One transaction, hit flag looked at in its single cycle
	task automatic txn(input logic [31:0] a, input logic io, input logic h, input logic [31:0] x);
		m.send(a, io);
		@(negedge clk);
		chk("fwd_hit", {31'h0, h}, {31'h0, hit});
		if (h) chk("fwd_addr", x, fwd);
	endtask : txn
	////////////////////////////////////////////////////////////////////////
	task automatic t_mem();
		rdchk("base", 12'h058, 32'h00000000);
		wr(12'h058, 32'hffffffff);
		rdchk("base", 12'h058, 32'h00000000);
		m.load(32'hffffffca);
		wr(12'h058, 32'hffffffff);
		rdchk("base", 12'h058, 32'hfffff00a);
	endtask : t_mem
	task automatic t_xlat();
		wr(12'h0e8, 32'h1234503f);
		rdchk("xlat", 12'h0e8, 32'h12345000);
		wr(12'h058, 32'h40000000);
		txn(32'h40000abc, 1'b0, 1'b1, 32'h12345abc);
		txn(32'h50000abc, 1'b0, 1'b0, 32'h0);
		txn(32'h40000abc, 1'b1, 1'b0, 32'h0);
		m.load(32'h7fffffca);
		txn(32'h40000abc, 1'b0, 1'b0, 32'h0);
		m.load(32'hffffffca);
		wr(12'h058, 32'h00000000);
		txn(32'h00000abc, 1'b0, 1'b0, 32'h0);
	endtask : t_xlat
	task automatic t_io();
		m.load(32'hffffffc1);
		wr(12'h058, 32'h00001140);
		rdchk("base", 12'h058, 32'h00001141);
		txn(32'h00001150, 1'b1, 1'b1, 32'h12345010);
		txn(32'h00001190, 1'b1, 1'b0, 32'h0);
	endtask : t_io
	task automatic t_unmap();
		logic [31:0] r;
		logic        e;
		apb(1'b1, 12'h100, 32'hffffffff, r, e);
		chk("pslverr", 32'h1, {31'h0, e});
		wr(12'h05c, 32'hffffffff);
		rdchk("win2", 12'h05c, 32'h00000000);
	endtask : t_unmap
	// Clock enable low freezes state; setup register is also writable from the bus
	task automatic t_ce();
		@(posedge clk);
		ce <= 1'b0;
		m.load(32'h00000000);
		ce <= 1'b1;
		rdchk("setup", 12'h0ec, 32'hffffffc1);
		wr(12'h0ec, 32'h800000cc);
		rdchk("setup", 12'h0ec, 32'h800000cc);
		rdchk("base", 12'h058, 32'h00000008);
		m.load(32'h00000000);
		rdchk("setup", 12'h0ec, 32'h00000000);
	endtask : t_ce
	initial begin
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		t_mem();
		t_xlat();
		t_io();
		t_unmap();
		t_ce();
		tally_and_finish();
	end
endmodule : upstream_window_base_regs_tb
